// *** core/bcvc_capture.sv ***
// Strap capture register holding the boot vector from each sample pulse until the next one or a cold reset
`include "bcvc_regs.svh"

module bcvc_capture (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sample,
  input wire logic [8:0] straps,
  output logic valid,
  output logic [8:0] vector
);
  // Vector only ever loads on the release pulse
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      vector <= 9'h000;
      valid <= 1'b0;
    end
    else if (sample)
    begin
      vector <= straps;
      valid <= 1'b1;
    end
  end
endmodule

// *** core/bcvc_pkg.sv ***
// Types shared by the boot configuration capture block
package bcvc_pkg;
  // Switch operating modes
  typedef enum logic [2:0] {
    BCVC_MODE_NORMAL = 3'h0,
    BCVC_MODE_EEPROM = 3'h1,
    BCVC_MODE_LOWLAT = 3'h2,
    BCVC_MODE_EEP_LOWLAT = 3'h3
  } bcvc_mode_t;

  // Reset sequencing states, Gray coded along the path
  typedef enum logic [1:0] {
    BCVC_ST_RESET = 2'b00,
    BCVC_ST_LOAD = 2'b01,
    BCVC_ST_HALT = 2'b11,
    BCVC_ST_RUN = 2'b10
  } bcvc_state_t;
endpackage

// *** core/bcvc_regs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef BCVC_REGS_SVH
`define BCVC_REGS_SVH

// Word-aligned byte offsets
`define BCVC_STATUS_OFS 4'h0
`define BCVC_CONTROL_OFS 4'h4
`define BCVC_LINK_US_OFS 4'h8
`define BCVC_LINK_DS_OFS 4'hC

// Status register fields
`define BCVC_ST_DS_BIT 0
`define BCVC_ST_US_BIT 1
`define BCVC_ST_SLOW_BIT 2
`define BCVC_ST_REFCLK_BIT 3
`define BCVC_ST_HALTSTRAP_BIT 4
`define BCVC_ST_MODE_LSB 5
`define BCVC_ST_AUXN_BIT 8
`define BCVC_ST_HALTIND_BIT 9
`define BCVC_ST_HELD_BIT 10
`define BCVC_ST_MODEBAD_BIT 11

// Control register fields
`define BCVC_CT_HALT_BIT 0
`define BCVC_CT_AUXN_BIT 1
`define BCVC_CT_FRST_BIT 2
`define BCVC_CT_STICKY_LSB 8

// Link status: one slot-clock bit per port; four downstream ports
`define BCVC_NUM_DS 4

// Sticky byte reset value
`define BCVC_STICKY_RST 8'h00

// SMBus rates and reference clocks
`define BCVC_CLK_HZ 100000000
`define BCVC_SMB_SLOW_HZ 100000
`define BCVC_SMB_FAST_HZ 400000
`define BCVC_SMB_SLOW_DIV (`BCVC_CLK_HZ / `BCVC_SMB_SLOW_HZ)
`define BCVC_SMB_FAST_DIV (`BCVC_CLK_HZ / `BCVC_SMB_FAST_HZ)
`define BCVC_REF_100_MHZ 100
`define BCVC_REF_125_MHZ 125

`endif

// *** core/bcvc_top.sv ***
// Boot configuration vector capture with Avalon-MM register slave
`include "bcvc_regs.svh"

module bcvc_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic fundamental_reset_n,
  input wire logic common_clock_downstream_strap,
  input wire logic common_clock_upstream_strap,
  input wire logic master_smbus_slow_strap,
  input wire logic refclk_freq_select,
  input wire logic reset_halt,
  input wire logic [2:0] switch_mode_strap,
  input wire logic aux_power_disable_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic eeprom_write,
  input wire logic [3:0] eeprom_address,
  input wire logic [31:0] eeprom_writedata,
  input wire logic eeprom_done,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic device_held,
  output logic smbus_active,
  output logic [15:0] smbus_clk_div,
  output logic [7:0] refclk_mhz,
  output logic [2:0] switch_mode,
  output logic eeprom_init_en,
  output logic low_latency_en,
  output logic aux_power_en,
  output logic warm_reset_req
);
  // Decode of a mode into its two feature flags
  function automatic logic [1:0] mode_flags(input logic [2:0] m);
    unique case (m)
      bcvc_pkg::BCVC_MODE_NORMAL: mode_flags = 2'b00;
      bcvc_pkg::BCVC_MODE_EEPROM: mode_flags = 2'b01;
      bcvc_pkg::BCVC_MODE_LOWLAT: mode_flags = 2'b10;
      bcvc_pkg::BCVC_MODE_EEP_LOWLAT: mode_flags = 2'b11;
      default: mode_flags = 2'b00;
    endcase
  endfunction

  // Previous level of the fundamental reset pin
  // Cleared low so a pin already high at cold reset still captures
  logic perst_q;
  // One-cycle pulse on pin release
  wire perst_rise = fundamental_reset_n & ~perst_q;
  // Raw strap vector
  wire [8:0] strap_bus = {aux_power_disable_n, switch_mode_strap,
    reset_halt, refclk_freq_select, master_smbus_slow_strap,
    common_clock_upstream_strap, common_clock_downstream_strap};
  // Captured vector
  logic [8:0] cap;
  logic cap_valid;
  // Fields of captured vector
  wire cap_ds = cap[0];
  wire cap_us = cap[1];
  wire cap_slow = cap[2];
  wire cap_ref = cap[3];
  wire cap_halt = cap[4];
  wire [2:0] cap_mode = cap[7:5];
  wire cap_auxn = cap[8];
  // Feature flags of the captured mode
  wire [1:0] flags = mode_flags(cap_mode);

  // Capture store, cleared only by cold reset
  bcvc_capture u_cap (
    .clk(clk),
    .resetn(resetn),
    .sample(perst_rise),
    .straps(strap_bus),
    .valid(cap_valid),
    .vector(cap)
  );

  // Sequencer state
  bcvc_pkg::bcvc_state_t state;
  bcvc_pkg::bcvc_state_t next_state;
  // Writable registers and halt indication
  logic ctl_halt;
  logic ctl_auxn;
  logic [7:0] sticky;
  logic halt_ind;
  logic link_us;
  logic [`BCVC_NUM_DS-1:0] link_ds;
  logic frst_pulse;
  // Second cycle of a bus access acknowledges it
  logic ack;

  // Write ports: EEPROM loader or bus master
  // A bus write lands only on the edge that completes the access,
  // when waitrequest is low, so side effects fire exactly once
  wire bus_wr = avs_write & ack;
  wire eep_wr = eeprom_write & (state == bcvc_pkg::BCVC_ST_LOAD);
  wire any_wr = bus_wr | eep_wr;
  wire [3:0] wr_addr = eep_wr ? eeprom_address : avs_address;
  wire [31:0] wr_data = eep_wr ? eeprom_writedata : avs_writedata;
  wire wr_ctl = any_wr & (wr_addr == `BCVC_CONTROL_OFS);
  wire wr_lus = any_wr & (wr_addr == `BCVC_LINK_US_OFS);
  wire wr_lds = any_wr & (wr_addr == `BCVC_LINK_DS_OFS);
  // Reload of strap-seeded values on each pin release
  wire seed = perst_rise;
  // Reuse earlier vector on software-initiated fundamental reset
  wire soft_seed = frst_pulse;
  wire reseed = seed | soft_seed;
  // Strap value applied at reseed
  wire [8:0] seed_vec = seed ? strap_bus : cap;

  // Pin history
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      perst_q <= 1'b0;
    else
      perst_q <= fundamental_reset_n;
  end

  // Sequencer next state
  always_comb
  begin
    next_state = state;
    unique case (state)
      bcvc_pkg::BCVC_ST_RESET:
        if (fundamental_reset_n && cap_valid)
          next_state = bcvc_pkg::BCVC_ST_LOAD;
      bcvc_pkg::BCVC_ST_LOAD:
        if (eeprom_done || !flags[0])
          next_state = bcvc_pkg::BCVC_ST_HALT;
      bcvc_pkg::BCVC_ST_HALT:
        if (!ctl_halt)
          next_state = bcvc_pkg::BCVC_ST_RUN;
      bcvc_pkg::BCVC_ST_RUN:
        next_state = bcvc_pkg::BCVC_ST_RUN;
    endcase
    if (!fundamental_reset_n || frst_pulse)
      next_state = bcvc_pkg::BCVC_ST_RESET;
  end

  // Sequencer register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state <= bcvc_pkg::BCVC_ST_RESET;
    else
      state <= next_state;
  end

  // Halt control bit: seeded, then writable
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctl_halt <= 1'b0;
    else if (reseed)
      ctl_halt <= seed_vec[4];
    else if (wr_ctl)
      ctl_halt <= wr_data[`BCVC_CT_HALT_BIT];
  end

  // Halt indication status bit
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      halt_ind <= 1'b0;
    else if (reseed)
      halt_ind <= seed_vec[4];
  end

  // Aux-power control: seeded from strap, overridable
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctl_auxn <= 1'b0;
    else if (reseed)
      ctl_auxn <= seed_vec[8];
    else if (wr_ctl)
      ctl_auxn <= wr_data[`BCVC_CT_AUXN_BIT];
  end

  // Fundamental-reset sticky byte
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sticky <= `BCVC_STICKY_RST;
    else if (reseed && !seed_vec[8])
      sticky <= `BCVC_STICKY_RST;
    else if (wr_ctl)
      sticky <= wr_data[`BCVC_CT_STICKY_LSB +: 8];
  end

  // Software warm reset request, one cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      frst_pulse <= 1'b0;
    else
      frst_pulse <= wr_ctl & wr_data[`BCVC_CT_FRST_BIT];
  end

  // Upstream slot-clock bit
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      link_us <= 1'b0;
    else if (reseed)
      link_us <= seed_vec[1];
    else if (wr_lus)
      link_us <= wr_data[0];
  end

  // Downstream slot-clock bits, one per port
  genvar gi;
  generate
    for (gi = 0; gi < `BCVC_NUM_DS; gi++)
    begin : g_ds
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          link_ds[gi] <= 1'b0;
        else if (reseed)
          link_ds[gi] <= seed_vec[0];
        else if (wr_lds)
          link_ds[gi] <= wr_data[gi];
      end
    end
  endgenerate

  // Bus acknowledge: one wait cycle per access
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ack <= 1'b0;
    else
      ack <= (avs_read | avs_write) & ~ack;
  end

  // Status word from captured vector; slow/mode/refclk not overridable
  wire [31:0] status_word = {20'h00000,
    (cap_mode[2] == 1'b1), (state != bcvc_pkg::BCVC_ST_RUN),
    halt_ind, cap_auxn, cap_mode, cap_halt, cap_ref, cap_slow,
    cap_us, cap_ds};
  wire [31:0] control_word = {16'h0000, sticky, 5'h00, 1'b0,
    ctl_auxn, ctl_halt};
  wire [31:0] read_mux =
    (avs_address == `BCVC_STATUS_OFS) ? status_word :
    (avs_address == `BCVC_CONTROL_OFS) ? control_word :
    (avs_address == `BCVC_LINK_US_OFS) ? {31'h00000000, link_us} :
    (avs_address == `BCVC_LINK_DS_OFS) ? {28'h0000000, link_ds} :
    32'h00000000;

  // Read data register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      avs_readdata <= 32'h00000000;
    else if (avs_read && !ack)
      avs_readdata <= read_mux;
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack;

  // Derived outputs
  wire held = (state != bcvc_pkg::BCVC_ST_RUN);

  // Output registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      device_held <= 1'b1;
      smbus_active <= 1'b0;
      smbus_clk_div <= 16'h0000;
      refclk_mhz <= 8'h00;
      switch_mode <= 3'h0;
      eeprom_init_en <= 1'b0;
      low_latency_en <= 1'b0;
      aux_power_en <= 1'b0;
      warm_reset_req <= 1'b0;
    end
    else
    begin
      device_held <= held;
      smbus_active <= (state != bcvc_pkg::BCVC_ST_RESET);
      smbus_clk_div <= cap_slow ? 16'(`BCVC_SMB_SLOW_DIV)
        : 16'(`BCVC_SMB_FAST_DIV);
      refclk_mhz <= cap_ref ? 8'(`BCVC_REF_125_MHZ)
        : 8'(`BCVC_REF_100_MHZ);
      switch_mode <= cap_mode;
      eeprom_init_en <= flags[0];
      low_latency_en <= flags[1];
      aux_power_en <= ctl_auxn;
      warm_reset_req <= frst_pulse;
    end
  end
endmodule

// *** verif/bcvc_asserts.sv ***
// Port-level timing checks for the boot vector capture block
module bcvc_asserts (
  input wire logic clk,
  input wire logic resetn,
  input wire logic fundamental_reset_n,
  input wire logic master_smbus_slow_strap,
  input wire logic refclk_freq_select,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic device_held,
  input wire logic smbus_active,
  input wire logic [15:0] smbus_clk_div,
  input wire logic [7:0] refclk_mhz,
  input wire logic [2:0] switch_mode,
  input wire logic eeprom_init_en,
  input wire logic low_latency_en,
  input wire logic warm_reset_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Pin steady long enough for any release to have settled
  sequence s_pin_high;
    fundamental_reset_n [*5];
  endsequence
  sequence s_pin_low;
    !fundamental_reset_n [*6];
  endsequence
  property p_quiet;
    s_pin_high |-> $stable(switch_mode) && $stable(refclk_mhz)
      && $stable(smbus_clk_div);
  endproperty
  // Rates follow the straps seen at the release, two edges later
  property p_slow;
    $rose(fundamental_reset_n) |-> ##2 smbus_clk_div ==
      ($past(master_smbus_slow_strap, 2) ? 16'h03E8 : 16'h00FA);
  endproperty
  property p_ref;
    $rose(fundamental_reset_n) |-> ##2 refclk_mhz ==
      ($past(refclk_freq_select, 2) ? 8'h7D : 8'h64);
  endproperty
  property p_mode;
    eeprom_init_en == (switch_mode == 3'h1 || switch_mode == 3'h3)
      && low_latency_en == (switch_mode == 3'h2 || switch_mode == 3'h3);
  endproperty
  property p_down;
    s_pin_low |-> !smbus_active;
  endproperty
  property p_held;
    !smbus_active |-> device_held;
  endproperty
  property p_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  property p_frst;
    warm_reset_req |=> !warm_reset_req;
  endproperty
  a_quiet: assert property (p_quiet) else $error("strap output moved");
  a_slow: assert property (p_slow) else $error("bad smbus divider");
  a_ref: assert property (p_ref) else $error("bad refclk value");
  a_mode: assert property (p_mode) else $error("mode decode wrong");
  a_down: assert property (p_down) else $error("active in reset");
  a_held: assert property (p_held) else $error("released in reset");
  a_wait: assert property (p_wait) else $error("wait too long");
  a_frst: assert property (p_frst) else $error("long warm pulse");
endmodule

// *** verif/bcvc_strap_model.sv ***
// Board straps driven from one packed vector, reset pin from pin_n
module bcvc_strap_model (
  input wire logic [8:0] vec,
  input wire logic pin_n,
  output logic fundamental_reset_n,
  output logic common_clock_downstream_strap,
  output logic common_clock_upstream_strap,
  output logic master_smbus_slow_strap,
  output logic refclk_freq_select,
  output logic reset_halt,
  output logic [2:0] switch_mode_strap,
  output logic aux_power_disable_n,
  output logic ssc_allowed
);
  timeunit 1ns;
  timeprecision 1ps;
  // Strap order matches the status register layout
  assign {aux_power_disable_n, switch_mode_strap, reset_halt,
    refclk_freq_select, master_smbus_slow_strap,
    common_clock_upstream_strap, common_clock_downstream_strap} = vec;
  assign fundamental_reset_n = pin_n;
  // Spread spectrum only with common clock on both sides
  assign ssc_allowed = vec[0] & vec[1];
endmodule

// *** verif/bcvc_top_tb_top.sv ***
// Self-checking bench for the boot vector capture block
module bcvc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic pin_n = 1'b0;
  logic [8:0] vec = 9'h000;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic eeprom_write = 1'b0;
  logic [3:0] eeprom_address = 4'hC;
  logic [31:0] eeprom_writedata = 32'h5;
  logic eeprom_done = 1'b0;
  logic [31:0] q;
  int n_mismatch = 0;
  int n_tests = 0;
  wire fundamental_reset_n, common_clock_downstream_strap, reset_halt;
  wire common_clock_upstream_strap, master_smbus_slow_strap;
  wire refclk_freq_select, aux_power_disable_n, avs_waitrequest;
  wire [2:0] switch_mode_strap, switch_mode;
  wire [31:0] avs_readdata;
  wire [15:0] smbus_clk_div;
  wire [7:0] refclk_mhz;
  wire device_held, smbus_active, eeprom_init_en, low_latency_en;
  wire aux_power_en, warm_reset_req;
  // Packed views of the decoded outputs, one compare each
  wire [31:0] rate_seen = {smbus_clk_div, refclk_mhz, 5'h00, switch_mode};
  wire [31:0] flags_seen = {28'h0, eeprom_init_en, low_latency_en,
    device_held, aux_power_en};
  wire [31:0] mode_seen = {30'h0, eeprom_init_en, low_latency_en};
  bcvc_strap_model u_bcvc_strap_model (.ssc_allowed(), .*);
  bcvc_top u_bcvc_top (.*);
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic wrap_up();
    $display("Mismatches %0d, checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  // One access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (avs_waitrequest !== 1'b0 && i < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  // Loader sets downstream clock bits, then reports completion
  task automatic load();
    @(posedge clk);
    eeprom_write <= 1'b1;
    @(posedge clk);
    eeprom_write <= 1'b0;
    eeprom_done <= 1'b1;
    @(posedge clk);
    eeprom_done <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic boot(input logic [8:0] v);
    @(posedge clk);
    pin_n <= 1'b0;
    vec <= v;
    repeat (7) @(posedge clk);
    pin_n <= 1'b1;
    repeat (4) @(posedge clk);
    load();
  endtask
  task automatic frst(input logic [31:0] d);
    bus(1'b1, 4'h4, d);
    repeat (6) @(posedge clk);
    load();
  endtask
  task automatic t_cold();
    boot(9'h175);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h00000775);
    chk(rate_seen, 32'h03E86403);
    chk(flags_seen, 32'hF);
    vec <= ~vec;
    repeat (5) @(posedge clk);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h00000775);
    bus(1'b0, 4'hC, 32'h0);
    chk(q, 32'h5);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'h3);
    bus(1'b1, 4'h4, 32'h2);
    repeat (4) @(posedge clk);
    chk({31'h0, device_held}, 32'h0);
    bus(1'b1, 4'h8, 32'h1);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h1);
    bus(1'b1, 4'h0, 32'hFFF);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h00000375);
    bus(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
  endtask
  // Software reset reuses the stored vector, sticky byte survives
  task automatic t_frst();
    bus(1'b1, 4'h4, 32'hA502);
    frst(32'hA506);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h00000775);
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'hA503);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 4'h4, 32'hA502);
  endtask
  task automatic t_aux();
    boot(9'h04E);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0000004E);
    chk(rate_seen, 32'h03E87D02);
    chk(flags_seen, 32'h4);
    bus(1'b0, 4'hC, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 4'h4, 32'h5A00);
    frst(32'h5A04);
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'h0);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 8; m++)
    begin
      boot({1'b1, 3'(m), 5'h01});
      chk(rate_seen, {16'h00FA, 8'h64, 5'h00, 3'(m)});
      chk(mode_seen, {30'h0, m == 1 || m == 3, m == 2 || m == 3});
      bus(1'b0, 4'h0, 32'h0);
      chk(q, {20'h0, m > 3, 2'b00, 1'b1, 3'(m), 5'h01});
      // Every downstream port seeds from the strap unless the loader ran
      bus(1'b0, 4'hC, 32'h0);
      chk(q, (m == 1 || m == 3) ? 32'h5 : 32'hF);
    end
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_cold();
    t_frst();
    t_aux();
    t_modes();
    wrap_up();
  end
endmodule
bind bcvc_top bcvc_asserts u_bcvc_asserts (.*);
